// [logic/wdg_map.svh]
`ifndef WDG_MAP_SVH
`define WDG_MAP_SVH

// Byte addresses on the register bus (index times four)
`define WDG_RESTART_IDX    8'hA6
`define WDG_PERIOD_IDX     8'hA7
`define WDG_RESTART_ADDR   12'h298
`define WDG_PERIOD_ADDR    12'h29C
`define WDG_CLKCFG_ADDR    12'h2A0
`define WDG_STATUS_ADDR    12'h2A4

// Field positions
`define WDG_TOSEL_MSB      2
`define WDG_CLKCFG_HALVE   0
`define WDG_CLKCFG_DOUBLE  1

// Reset values
`define WDG_TOSEL_RST      3'h0
`define WDG_CLKCFG_RST     2'h0

// Restart sequence bytes
`define WDG_KEY_FIRST      8'h1E
`define WDG_KEY_SECOND     8'hE1

// Timing
`define WDG_PRESCALE_BITS  14
`define WDG_COUNT_BITS     7
`define WDG_TIMEOUT_MULT   3'h6
`define WDG_RST_PULSE_OSC  96
`define WDG_RST_PULSE_CYC  7'h60

`endif

// [logic/wdg_pkg.sv]
package wdg_pkg;

   typedef struct packed {
      logic       halve_sel;
      logic       double_speed;
   } wdg_clkcfg_t;

   typedef struct packed {
      logic       enabled;
      logic       rst_active;
      logic       first_seen;
      logic [2:0] tosel_live;
   } wdg_status_t;

   typedef enum logic [1:0] {
      WDG_KEY_IDLE  = 2'b01,
      WDG_KEY_ARMED = 2'b10
   } wdg_key_t;

endpackage

// [logic/wdg_tick_gen.sv]
`timescale 1ns/10ps
`include "wdg_map.svh"

// Watchdog clock enable: every second oscillator cycle or every cycle
module wdg_tick_gen
(
   // Clock and reset
   input  wire logic              aclk,
   input  wire logic              aresetn,
   // Control
   input  wire wdg_pkg::wdg_clkcfg_t cfg,
   input  wire logic              run,
   // Output
   output logic                   tick
);

   logic phase_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         phase_r <= 1'b0;
      else if (run)
         phase_r <= ~phase_r;
   end

   // Halving unless double speed and halving not forced
   always_comb
   begin
      if (cfg.halve_sel || !cfg.double_speed)
         tick = run && phase_r;
      else
         tick = run;
   end

endmodule // wdg_tick_gen

// [logic/wdg_pulse_gen.sv]
`timescale 1ns/10ps
`include "wdg_map.svh"

// Stretches an overflow into a fixed-length chip reset pulse
module wdg_pulse_gen
(
   // Clock and reset
   input  wire logic aclk,
   input  wire logic aresetn,
   // Trigger
   input  wire logic fire,
   // Pulse
   output logic      pulse
);

   logic [6:0] cnt_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         cnt_r <= 7'h00;
      else if (fire && cnt_r == 7'h00)
         cnt_r <= `WDG_RST_PULSE_CYC;
      else if (cnt_r != 7'h00)
         cnt_r <= cnt_r - 7'h01;
   end

   assign pulse = (cnt_r != 7'h00);

endmodule // wdg_pulse_gen

// [logic/wdg_top.sv]
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/10ps
`include "wdg_map.svh"

// Operation
// - Clock halved unless double speed and unforced
// - Disabled and stopped after chip reset
// - Bytes 1Eh then E1h enable and clear
// - Once enabled, only chip reset disables
// - Uncleared time-out forces whole-chip reset
// - Overflow drives 96-cycle high reset pulse
// - Time-out is 6 x 2^14 x 2^select ticks
// - Three-bit select in bits 2-0, resets zero
// - Counting continues during idle mode
// - Power-down freezes the count
// - Interrupt wake resumes from held count
// - Reset wake clears and disables
// - Restart register write-only, sequence receiver
// - Period bits 7-3 reserved, write zero
// - 14-bit prescaler feeds 7-bit counter
module wdg_top
(
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Power state
   input  wire logic        power_down,
   // Chip reset request
   output logic             chip_reset
);

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   logic [11:0]          awaddr_r;
   logic                 aw_held_r;
   logic [7:0]           wbyte_r;
   logic                 wlane0_r;
   logic                 w_held_r;
   logic                 bvalid_r;
   logic [1:0]           bresp_r;
   logic                 rvalid_r;
   logic [31:0]          rdata_r;
   logic [1:0]           rresp_r;
   logic                 do_write;
   logic                 do_read;

   logic [2:0]           tosel_r;
   logic [2:0]           tosel_live_r;
   wdg_pkg::wdg_clkcfg_t clkcfg_r;
   wdg_pkg::wdg_key_t    key_r;
   logic                 enabled_r;
   logic                 restart;
   logic                 wr_restart;
   logic                 wr_period;
   logic                 wr_clkcfg;
   logic                 tick;
   logic [13:0]          presc_r;
   logic [2:0]           six_r;
   logic                 six_wrap;
   logic                 presc_carry;
   logic                 six_carry;
   logic [6:0]           cnt_r;
   logic [6:0]           count_limit;
   logic                 presc_wrap;
   logic                 overflow;
   logic                 pulse;
   wdg_pkg::wdg_status_t status;

   // Write channel: address and data taken in either order, one at a time
   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready  = !w_held_r && !bvalid_r;
   assign do_write      = aw_held_r && w_held_r && !bvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held_r <= 1'b0;
         awaddr_r  <= 12'h000;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_held_r <= 1'b1;
         awaddr_r  <= s_axi_awaddr;
      end
      else if (do_write)
         aw_held_r <= 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_held_r <= 1'b0;
         wbyte_r  <= 8'h00;
         wlane0_r <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_held_r <= 1'b1;
         wbyte_r  <= s_axi_wdata[7:0];
         wlane0_r <= s_axi_wstrb[0];
      end
      else if (do_write)
         w_held_r <= 1'b0;
   end

   // Byte-wide registers only react to a write that carries lane 0
   assign wr_restart = do_write && wlane0_r && awaddr_r == `WDG_RESTART_ADDR;
   assign wr_period  = do_write && wlane0_r && awaddr_r == `WDG_PERIOD_ADDR;
   assign wr_clkcfg  = do_write && wlane0_r && awaddr_r == `WDG_CLKCFG_ADDR;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_r <= 1'b0;
         bresp_r  <= RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_r <= 1'b1;
         case (awaddr_r)
            `WDG_RESTART_ADDR, `WDG_PERIOD_ADDR, `WDG_CLKCFG_ADDR: bresp_r <= RESP_OKAY;
            default:                                               bresp_r <= RESP_SLVERR;
         endcase
      end
      else if (s_axi_bready)
         bvalid_r <= 1'b0;
   end

   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp  = bresp_r;

   // Read channel: answer one cycle after the address is taken
   assign s_axi_arready = !rvalid_r;
   assign do_read       = s_axi_arvalid && !rvalid_r;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= RESP_OKAY;
      end
      else if (do_read)
      begin
         rvalid_r <= 1'b1;
         rresp_r  <= RESP_OKAY;
         case (s_axi_araddr)
            // Write-only: the sequence receiver holds no readable value
            `WDG_RESTART_ADDR: rdata_r <= 32'h0000_0000;
            // Reserved bits read as zero here
            `WDG_PERIOD_ADDR:  rdata_r <= {29'h0000_0000, tosel_r};
            `WDG_CLKCFG_ADDR:  rdata_r <= {30'h0000_0000, clkcfg_r.double_speed, clkcfg_r.halve_sel};
            `WDG_STATUS_ADDR:  rdata_r <= {26'h000_0000, status};
            default:
            begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= RESP_SLVERR;
            end
         endcase
      end
      else if (s_axi_rready)
         rvalid_r <= 1'b0;
   end

   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata  = rdata_r;
   assign s_axi_rresp  = rresp_r;

   // Period register: only the select field is stored
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tosel_r <= `WDG_TOSEL_RST;
      else if (wr_period)
         tosel_r <= wbyte_r[`WDG_TOSEL_MSB:0];
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         clkcfg_r <= `WDG_CLKCFG_RST;
      else if (wr_clkcfg)
      begin
         clkcfg_r.halve_sel    <= wbyte_r[`WDG_CLKCFG_HALVE];
         clkcfg_r.double_speed <= wbyte_r[`WDG_CLKCFG_DOUBLE];
      end
   end

   // Two-byte key detector
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         key_r <= wdg_pkg::WDG_KEY_IDLE;
      else if (wr_restart)
      begin
         case (key_r)
            wdg_pkg::WDG_KEY_IDLE:
               key_r <= (wbyte_r == `WDG_KEY_FIRST) ? wdg_pkg::WDG_KEY_ARMED : wdg_pkg::WDG_KEY_IDLE;
            wdg_pkg::WDG_KEY_ARMED:
               // A repeated first byte keeps the detector armed
               key_r <= (wbyte_r == `WDG_KEY_FIRST) ? wdg_pkg::WDG_KEY_ARMED : wdg_pkg::WDG_KEY_IDLE;
            default:
               key_r <= wdg_pkg::WDG_KEY_IDLE;
         endcase
      end
   end

   assign restart = wr_restart && key_r == wdg_pkg::WDG_KEY_ARMED && wbyte_r == `WDG_KEY_SECOND;

   // Enable latch: the chip reset from this block clears it via aresetn
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         enabled_r <= 1'b0;
      else if (restart)
         enabled_r <= 1'b1;
   end

   // Select latched at each clear so a live change cannot cut the period short
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         tosel_live_r <= `WDG_TOSEL_RST;
      else if (restart)
         tosel_live_r <= tosel_r;
   end

   // Power-down halts the tick; idle is not seen here at all
   wdg_tick_gen u_tick
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .cfg     (clkcfg_r),
      .run     (enabled_r && !power_down),
      .tick    (tick)
   );

   // Seven bits cannot hold 6 * 2^7 wraps, so the factor six is a stage of its own
   always_comb
   begin
      case (tosel_live_r)
         3'h0:    count_limit = 7'h00;
         3'h1:    count_limit = 7'h01;
         3'h2:    count_limit = 7'h03;
         3'h3:    count_limit = 7'h07;
         3'h4:    count_limit = 7'h0F;
         3'h5:    count_limit = 7'h1F;
         3'h6:    count_limit = 7'h3F;
         default: count_limit = 7'h7F;
      endcase
   end

   assign presc_wrap  = (presc_r == 14'h3FFF);
   assign six_wrap    = (six_r == `WDG_TIMEOUT_MULT - 3'h1);
   assign presc_carry = tick && presc_wrap;
   assign six_carry   = presc_carry && six_wrap;
   assign overflow    = enabled_r && six_carry && cnt_r == count_limit;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
         presc_r <= 14'h0000;
      else if (tick)
         presc_r <= presc_r + 14'h0001;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart)
         six_r <= 3'h0;
      else if (presc_carry)
         six_r <= six_wrap ? 3'h0 : six_r + 3'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn || restart || overflow)
         cnt_r <= 7'h00;
      else if (six_carry)
         cnt_r <= cnt_r + 7'h01;
   end

   wdg_pulse_gen u_pulse
   (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fire    (overflow),
      .pulse   (pulse)
   );

   assign chip_reset = pulse;

   assign status.enabled    = enabled_r;
   assign status.rst_active = pulse;
   assign status.first_seen = (key_r == wdg_pkg::WDG_KEY_ARMED);
   assign status.tosel_live = tosel_live_r;

endmodule // wdg_top

// [tb/wdg_top_properties.sv]
`timescale 1ns/10ps
module wdg_props
(
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Reset request
   input wire logic        chip_reset
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Cycles the pulse has been high so far
   logic [7:0] hi_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         hi_r <= 8'h00;
      else
         hi_r <= chip_reset ? hi_r + 8'h01 : 8'h00;
   end
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_pulse_end;
      $fell(chip_reset);
   endsequence
   property p_wr_ans; s_wr_taken |-> ##2 s_axi_bvalid; endproperty
   property p_rd_ans;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000;
   endproperty
   property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
   property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
   property p_b_block; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
   property p_r_block; s_axi_rvalid |-> !s_axi_arready; endproperty
   property p_b_clear; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
   property p_pulse_max; chip_reset |-> hi_r < 8'h60; endproperty
   property p_pulse_len; s_pulse_end |-> hi_r == 8'h60; endproperty
   a_wr_ans: assert property (p_wr_ans) else $error("write answer missing");
   a_rd_ans: assert property (p_rd_ans) else $error("read answer missing");
   a_b_hold: assert property (p_b_hold) else $error("bvalid dropped");
   a_r_hold: assert property (p_r_hold) else $error("read data moved");
   a_b_block: assert property (p_b_block) else $error("write taken during response");
   a_r_block: assert property (p_r_block) else $error("read taken during response");
   a_b_clear: assert property (p_b_clear) else $error("bvalid stuck");
   a_pulse_max: assert property (p_pulse_max) else $error("pulse too long");
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
endmodule // wdg_props

bind wdg_top wdg_props u_props (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
   .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
   .s_axi_rvalid, .s_axi_rready, .chip_reset);

// [tb/testbench.sv]
`timescale 1ns/10ps
`include "wdg_map.svh"
module testbench;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [11:0] s_axi_awaddr = 12'h000;
   logic [11:0] s_axi_araddr = 12'h000;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0]  s_axi_wstrb = 4'h0;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        power_down = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, chip_reset;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   int unsigned cyc = 0;
   int unsigned t0;
   int          n_fail = 0;
   int          compares = 0;
   int          i;
   wdg_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .power_down, .chip_reset);
   always #5 aclk = ~aclk;
   always @(posedge aclk) cyc <= cyc + 1;
   task end_sim;
      $display("compares %0d n_fail %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      compares++;
      if (s !== e)
      begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   // Extra edge at the end so the next call never reassigns in the same step
   task wr(input logic [11:0] a, input logic [7:0] d);
      int t;
      t = 0;
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
         t++;
      end while (s_axi_bvalid !== 1'b1 && t < 50);
      chk("bresp", {s_axi_bvalid, s_axi_bresp}, 3'h4);
      s_axi_bready <= 1'b0;
      @(posedge aclk);
   endtask
   task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
      int t;
      t = 0;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
         t++;
      end while (s_axi_rvalid !== 1'b1 && t < 50);
      chk("rdata", s_axi_rdata, e);
      chk("rresp", {s_axi_rvalid, s_axi_rresp}, {1'b1, er});
      s_axi_rready <= 1'b0;
      @(posedge aclk);
   endtask
   initial
   begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`WDG_STATUS_ADDR, 8'h00, 2'h0);
      rd(`WDG_PERIOD_ADDR, 8'h00, 2'h0);
      rd(`WDG_RESTART_ADDR, 8'h00, 2'h0);
      rd(12'h100, 8'h00, 2'h2);
      wr(`WDG_PERIOD_ADDR, 8'h05);
      rd(`WDG_PERIOD_ADDR, 8'h05, 2'h0);
      wr(`WDG_PERIOD_ADDR, 8'h00);
      // Undivided tick keeps the full time-out inside the run
      wr(`WDG_CLKCFG_ADDR, 8'h02);
      rd(`WDG_CLKCFG_ADDR, 8'h02, 2'h0);
      wr(`WDG_RESTART_ADDR, 8'h1E);
      rd(`WDG_STATUS_ADDR, 8'h08, 2'h0);
      wr(`WDG_RESTART_ADDR, 8'h55);
      wr(`WDG_RESTART_ADDR, 8'hE1);
      rd(`WDG_STATUS_ADDR, 8'h00, 2'h0);
      wr(`WDG_RESTART_ADDR, 8'h1E);
      wr(`WDG_RESTART_ADDR, 8'hE1);
      wr(`WDG_RESTART_ADDR, 8'h00);
      wr(`WDG_PERIOD_ADDR, 8'h07);
      rd(`WDG_STATUS_ADDR, 8'h20, 2'h0);
      // Select 0 again so the clear before power-down keeps the short time-out
      wr(`WDG_PERIOD_ADDR, 8'h00);
      wr(`WDG_RESTART_ADDR, 8'h1E);
      wr(`WDG_RESTART_ADDR, 8'hE1);
      t0 = cyc;
      power_down <= 1'b1;
      repeat (500) @(posedge aclk);
      power_down <= 1'b0;
      // 608 halved cycles, forced then standard, lose 304 ticks
      wr(`WDG_CLKCFG_ADDR, 8'h03);
      repeat (300) @(posedge aclk);
      wr(`WDG_CLKCFG_ADDR, 8'h00);
      repeat (300) @(posedge aclk);
      wr(`WDG_CLKCFG_ADDR, 8'h02);
      for (i = 0; i < 100000 && chip_reset !== 1'b1; i++) @(posedge aclk);
      chk("timeout", cyc - t0 + 4 - 99108 < 12, 1'b1);
      for (i = 0; i < 200 && chip_reset === 1'b1; i++) @(posedge aclk);
      chk("pulse", i, 96);
      aresetn <= 1'b0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(`WDG_STATUS_ADDR, 8'h00, 2'h0);
      end_sim;
   end
   initial
   begin
      #1200000;
      n_fail++;
      end_sim;
   end
endmodule // testbench
